// file: ddi_top.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Config bit 4 picks 8 or 10-bit
// - 8-bit writes shift left two, zero LSBs
// - Byte transfers in 8-bit, half-word otherwise
// - Trigger off: latch loads one cycle after
// - Trigger on: timer rising edge loads latch
// - Source codes 0-5 pick timer, 11x reserved
// - Source field ignored while trigger off
// - Drained flag low while holding value waits
// - Flag zero when trigger off, set enabling
// - Enable-set write one sets mask bit
// - Enable-clear write one clears mask bit
// - Control bit 0 reinitialises the interface
// - Holding reads right-aligned, upper bits zero
// - Output latch reads right-aligned, resets zero
// - Output latch never written by software
module ddi_top #(
    parameter int TIMERS = ddi_pkg::TIMER_N
) (
    input wire logic MCLK, // Main clock
    input wire logic RESET_N, // Async reset, low
    input wire logic [7:0] REG_ADDR, // Register byte address
    input wire logic [31:0] REG_WDATA, // Write data
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    output logic [31:0] REG_RDATA, // Read data, cycle after strobe
    input wire logic [TIMERS-1:0] TIMER_WAVE_OUT_A, // Timer waveform outputs
    output logic [ddi_pkg::SAMPLE_W-1:0] SAMPLE_OUT, // Code to analog core
    output logic XFER_BYTE, // Transfer channel byte size
    output logic XFER_HALFWORD, // Transfer channel half-word size
    output logic IRQ // Level interrupt
);
    import ddi_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic rst_meta_ff, rst_n_sync;
    // Release through two flops
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_ff <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_sync <= rst_meta_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // State declarations
    logic hw_trigger_enable_ff, nxt_hw_trigger_enable;
    logic [SRC_W-1:0] timer_source_select_ff, nxt_timer_source_select;
    logic width_select_8bit_ff, nxt_width_select_8bit;
    logic [SAMPLE_W-1:0] holding_ff, nxt_holding;
    logic [SAMPLE_W-1:0] out_latch_ff, nxt_out_latch;
    logic holding_drained_flag_ff, nxt_holding_drained_flag;
    ddi_xfer_e xfer_ff, nxt_xfer;
    logic [IRQ_W-1:0] mask_ff, nxt_mask;
    logic [IRQ_W-1:0] events_ff, nxt_events, ev_new;
    logic [TIMERS-1:0] wave_prev_ff, nxt_wave_prev;
    logic [31:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic xfer_byte_ff, nxt_xfer_byte;
    logic xfer_half_ff, nxt_xfer_half;
    ////////////////////////////////////////////////////////////////////////////
    // Strobe decode
    logic wr_ctrl, wr_cfg, wr_hold, wr_set, wr_clr, wr_ev;
    logic soft_reinit;
    assign wr_ctrl = REG_WR && hit(REG_ADDR, OFS_CONTROL);
    assign wr_cfg = REG_WR && hit(REG_ADDR, OFS_CONFIG);
    assign wr_hold = REG_WR && hit(REG_ADDR, OFS_HOLDING);
    assign wr_set = REG_WR && hit(REG_ADDR, OFS_IRQ_SET);
    assign wr_clr = REG_WR && hit(REG_ADDR, OFS_IRQ_CLR);
    assign wr_ev = REG_WR && hit(REG_ADDR, OFS_EVENTS);
    assign soft_reinit = wr_ctrl && REG_WDATA[BIT_SOFT_REINIT];
    ////////////////////////////////////////////////////////////////////////////
    // Timer rising edge detection
    logic [TIMERS-1:0] wave_rise;
    genvar gi;
    generate
        for (gi = 0; gi < TIMERS; gi++) begin : g_rise
            assign wave_rise[gi] = TIMER_WAVE_OUT_A[gi] && !wave_prev_ff[gi];
        end
    endgenerate
    logic sel_rise;
    always_comb begin
        sel_rise = 1'b0;
        if (timer_source_select_ff < SRC_W'(TIMERS)) begin
            sel_rise = wave_rise[timer_source_select_ff];
        end
    end
    logic hw_fire;
    assign hw_fire = hw_trigger_enable_ff && sel_rise;
    ////////////////////////////////////////////////////////////////////////////
    // Write data formatting
    logic [SAMPLE_W-1:0] wr_sample;
    always_comb begin
        if (width_select_8bit_ff) begin
            wr_sample = {REG_WDATA[7:0], 2'b00};
        end else begin
            wr_sample = REG_WDATA[SAMPLE_W-1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Converter next-state logic
    always_comb begin
        nxt_hw_trigger_enable = hw_trigger_enable_ff;
        nxt_timer_source_select = timer_source_select_ff;
        nxt_width_select_8bit = width_select_8bit_ff;
        nxt_holding = holding_ff;
        nxt_out_latch = out_latch_ff;
        nxt_holding_drained_flag = holding_drained_flag_ff;
        nxt_xfer = xfer_ff;
        nxt_mask = mask_ff;
        nxt_events = events_ff;
        nxt_wave_prev = TIMER_WAVE_OUT_A;
        ev_new = RST_IRQ;
        // Software-paced transfer
        case (xfer_ff)
            XFER_IDLE: begin
                nxt_xfer = XFER_IDLE;
            end
            XFER_PEND: begin
                nxt_xfer = XFER_IDLE;
                if (!hw_trigger_enable_ff) begin
                    nxt_out_latch = holding_ff;
                    ev_new[BIT_EV_XFER] = 1'b1;
                end
            end
            default: begin
                nxt_xfer = XFER_IDLE;
            end
        endcase
        if (hw_fire) begin
            nxt_out_latch = holding_ff;
            nxt_holding_drained_flag = 1'b1;
            ev_new[BIT_EV_XFER] = 1'b1;
        end
        if (wr_cfg) begin
            nxt_hw_trigger_enable = REG_WDATA[BIT_HW_TRIG_EN];
            nxt_timer_source_select = REG_WDATA[BIT_SRC_LO +: SRC_W];
            nxt_width_select_8bit = REG_WDATA[BIT_WIDTH_8];
            if (REG_WDATA[BIT_HW_TRIG_EN] && !hw_trigger_enable_ff) begin
                nxt_holding_drained_flag = 1'b1;
            end
        end
        if (wr_hold) begin
            nxt_holding = wr_sample;
            if (hw_trigger_enable_ff) begin
                // Unsent value being replaced
                if (!holding_drained_flag_ff && !hw_fire) begin
                    ev_new[BIT_EV_OVERWRITE] = 1'b1;
                end
                nxt_holding_drained_flag = 1'b0;
            end else begin
                nxt_xfer = XFER_PEND;
            end
        end
        if (!nxt_hw_trigger_enable) begin
            nxt_holding_drained_flag = 1'b0;
        end
        if (wr_set) begin
            nxt_mask = mask_ff | REG_WDATA[IRQ_W-1:0];
        end
        if (wr_clr) begin
            nxt_mask = mask_ff & ~REG_WDATA[IRQ_W-1:0];
        end
        // Write one clears events, new set wins
        nxt_events = events_ff | ev_new;
        if (wr_ev) begin
            nxt_events = (events_ff & ~REG_WDATA[IRQ_W-1:0]) | ev_new;
        end
        nxt_events[BIT_DRAINED] = 1'b0;
        if (soft_reinit) begin
            nxt_hw_trigger_enable = 1'b0;
            nxt_timer_source_select = RST_SRC;
            nxt_width_select_8bit = 1'b0;
            nxt_holding = RST_SAMPLE;
            nxt_out_latch = RST_SAMPLE;
            nxt_holding_drained_flag = 1'b0;
            nxt_xfer = XFER_IDLE;
            nxt_mask = RST_IRQ;
            nxt_events = RST_IRQ;
        end
    end
    // Converter registers
    always_ff @(posedge MCLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            hw_trigger_enable_ff <= 1'b0;
            timer_source_select_ff <= RST_SRC;
            width_select_8bit_ff <= 1'b0;
            holding_ff <= RST_SAMPLE;
            out_latch_ff <= RST_SAMPLE;
            holding_drained_flag_ff <= 1'b0;
            xfer_ff <= XFER_IDLE;
            mask_ff <= RST_IRQ;
            events_ff <= RST_IRQ;
            wave_prev_ff <= '0;
        end else begin
            hw_trigger_enable_ff <= nxt_hw_trigger_enable;
            timer_source_select_ff <= nxt_timer_source_select;
            width_select_8bit_ff <= nxt_width_select_8bit;
            holding_ff <= nxt_holding;
            out_latch_ff <= nxt_out_latch;
            holding_drained_flag_ff <= nxt_holding_drained_flag;
            xfer_ff <= nxt_xfer;
            mask_ff <= nxt_mask;
            events_ff <= nxt_events;
            wave_prev_ff <= nxt_wave_prev;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read mux, interrupt and size outputs
    always_comb begin
        nxt_rdata = RST_WORD;
        if (REG_RD) begin
            case (REG_ADDR)
                OFS_CONFIG: begin
                    nxt_rdata[BIT_HW_TRIG_EN] = hw_trigger_enable_ff;
                    nxt_rdata[BIT_SRC_LO +: SRC_W] = timer_source_select_ff;
                    nxt_rdata[BIT_WIDTH_8] = width_select_8bit_ff;
                end
                OFS_HOLDING: begin
                    nxt_rdata[SAMPLE_W-1:0] = holding_ff;
                end
                OFS_OUT_LATCH: begin
                    nxt_rdata[SAMPLE_W-1:0] = out_latch_ff;
                end
                OFS_STATE: begin
                    nxt_rdata[BIT_DRAINED] = holding_drained_flag_ff;
                end
                OFS_IRQ_MASK: begin
                    nxt_rdata[IRQ_W-1:0] = mask_ff;
                end
                OFS_EVENTS: begin
                    nxt_rdata[IRQ_W-1:0] = events_ff;
                end
                default: begin
                    nxt_rdata = RST_WORD;
                end
            endcase
        end
        // flag raises interrupt when masked in
        nxt_irq = (nxt_holding_drained_flag && nxt_mask[BIT_DRAINED])
            || |(nxt_events & nxt_mask);
        nxt_xfer_byte = nxt_width_select_8bit;
        nxt_xfer_half = !nxt_width_select_8bit;
    end
    // Output registers
    always_ff @(posedge MCLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rdata_ff <= RST_WORD;
            irq_ff <= 1'b0;
            xfer_byte_ff <= 1'b0;
            xfer_half_ff <= 1'b1;
        end else begin
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            xfer_byte_ff <= nxt_xfer_byte;
            xfer_half_ff <= nxt_xfer_half;
        end
    end
    assign REG_RDATA = rdata_ff;
    assign SAMPLE_OUT = out_latch_ff;
    assign XFER_BYTE = xfer_byte_ff;
    assign XFER_HALFWORD = xfer_half_ff;
    assign IRQ = irq_ff;
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_res8_shift;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_hold && width_select_8bit_ff) |=> (holding_ff == {$past(REG_WDATA[7:0]), 2'b00});
    endproperty
    a_res8_shift: assert property (p_res8_shift) else $error("8-bit shift wrong");
    property p_res10;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_hold && !width_select_8bit_ff) |=> (holding_ff == $past(REG_WDATA[SAMPLE_W-1:0]));
    endproperty
    a_res10: assert property (p_res10) else $error("10-bit store wrong");
    property p_sw_xfer;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_hold && !hw_trigger_enable_ff) ##1 (!hw_trigger_enable_ff && !soft_reinit)
        |=> (out_latch_ff == $past(holding_ff));
    endproperty
    a_sw_xfer: assert property (p_sw_xfer) else $error("Latch not loaded");
    property p_hw_edge;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (hw_fire && !soft_reinit) |=> (out_latch_ff == $past(holding_ff))
        && (holding_drained_flag_ff || $past(wr_hold || !nxt_hw_trigger_enable));
    endproperty
    a_hw_edge: assert property (p_hw_edge) else $error("Edge transfer lost");
    property p_off_stable;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (!hw_trigger_enable_ff && xfer_ff == XFER_IDLE && !soft_reinit) |=> $stable(out_latch_ff);
    endproperty
    a_off_stable: assert property (p_off_stable) else $error("Latch moved idle");
    property p_flag_off;
        @(posedge MCLK) disable iff (!rst_n_sync)
        !hw_trigger_enable_ff |-> !holding_drained_flag_ff;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("Flag set while off");
    property p_flag_wr;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_hold && hw_trigger_enable_ff) |=> !holding_drained_flag_ff;
    endproperty
    a_flag_wr: assert property (p_flag_wr) else $error("Flag not cleared");
    property p_mask_set;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_set && REG_WDATA[BIT_DRAINED] && !soft_reinit) |=> mask_ff[BIT_DRAINED] ##1 1'b1;
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("Mask not set");
    property p_mask_clr;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_clr && REG_WDATA[BIT_DRAINED]) |=> !mask_ff[BIT_DRAINED];
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("Mask not cleared");
    property p_reinit;
        @(posedge MCLK) disable iff (!rst_n_sync)
        soft_reinit |=> (out_latch_ff == RST_SAMPLE) && !hw_trigger_enable_ff && !IRQ;
    endproperty
    a_reinit: assert property (p_reinit) else $error("Reinit incomplete");
    property p_rd_upper;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (REG_RD && (REG_ADDR == OFS_HOLDING || REG_ADDR == OFS_OUT_LATCH))
        |=> (REG_RDATA[31:SAMPLE_W] == '0);
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("Upper bits set");
    property p_size;
        @(posedge MCLK) disable iff (!rst_n_sync)
        (wr_cfg && !soft_reinit) |=> (XFER_BYTE == $past(REG_WDATA[BIT_WIDTH_8]))
        && (XFER_HALFWORD != XFER_BYTE);
    endproperty
    a_size: assert property (p_size) else $error("Transfer size wrong");
endmodule

`default_nettype wire

// file: ddi_pkg.sv
package ddi_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_HOLDING = 8'h08;
    localparam logic [7:0] OFS_OUT_LATCH = 8'h0c;
    localparam logic [7:0] OFS_STATE = 8'h10;
    localparam logic [7:0] OFS_IRQ_SET = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFS_EVENTS = 8'h20;
    // Field positions
    localparam int BIT_SOFT_REINIT = 0;
    localparam int BIT_HW_TRIG_EN = 0;
    localparam int BIT_SRC_LO = 1;
    localparam int BIT_WIDTH_8 = 4;
    localparam int BIT_DRAINED = 0;
    localparam int BIT_EV_XFER = 1;
    localparam int BIT_EV_OVERWRITE = 2;
    // Widths
    localparam int SAMPLE_W = 10;
    localparam int SRC_W = 3;
    localparam int IRQ_W = 3;
    localparam int TIMER_N = 6;
    // Reset values
    localparam logic [SAMPLE_W-1:0] RST_SAMPLE = 10'h000;
    localparam logic [SRC_W-1:0] RST_SRC = 3'h0;
    localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Transfer sequencing for the software-triggered path
    typedef enum logic [0:0] {
        XFER_IDLE = 1'b0,
        XFER_PEND = 1'b1
    } ddi_xfer_e;
endpackage

// file: ddi_timer_model.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Timer channels as seen by the converter front end
module ddi_timer_model #(
    parameter int N = 6,
    parameter int HIGH_CYC = 3
) (
    input wire logic clk, // Main clock
    input wire logic fire, // Start one waveform period
    input wire logic [2:0] idx, // Channel to run
    output logic [N-1:0] wave // Waveform outputs
);
    int cnt_ff [N];

    always @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            if (fire && idx == 3'(i)) begin
                cnt_ff[i] <= HIGH_CYC;
            end else if (cnt_ff[i] > 0) begin
                cnt_ff[i] <= cnt_ff[i] - 1;
            end
        end
    end

    // High while a period runs, low otherwise
    always_comb begin
        for (int i = 0; i < N; i++) begin
            wave[i] = (cnt_ff[i] > 0);
        end
    end
endmodule

`default_nettype wire

// file: ddi_top_tb.sv
`timescale 1ns/1ns
`default_nettype none

module ddi_top_tb;
    import ddi_pkg::*;
    localparam int LIMIT = 20000;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire = 1'b0;
    logic [2:0] fidx = 3'h0;
    logic rd_q = 1'b0;
    logic [31:0] rdata;
    logic [TIMER_N-1:0] wave;
    logic [SAMPLE_W-1:0] sample;
    logic xbyte;
    logic xhalf;
    logic irq;
    logic [31:0] exp_q [$];
    string name_q [$];
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int unsigned seed;
    logic [SAMPLE_W-1:0] exp_out = 10'h000;
    logic [31:0] w;
    logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h20, 8'h24};

    ////////////////////////////////////////////////////////////////////////////
    // Design and timer partner
    ddi_top #(.TIMERS(TIMER_N)) u_ddi_top (
        .MCLK(mclk), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TIMER_WAVE_OUT_A(wave),
        .SAMPLE_OUT(sample), .XFER_BYTE(xbyte), .XFER_HALFWORD(xhalf), .IRQ(irq)
    );
    ddi_timer_model #(.N(TIMER_N), .HIGH_CYC(3)) u_ddi_timer_model (
        .clk(mclk), .fire(fire), .idx(fidx), .wave(wave)
    );

    // Clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            close_out();
        end
    end

    // Read monitor against the oldest note
    always @(posedge mclk) rd_q <= rd;
    always @(negedge mclk) begin
        if (rd_q === 1'b1 && exp_q.size() > 0) begin
            check(name_q.pop_front(), rdata, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string what);
        exp_q.push_back(e);
        name_q.push_back(what);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic pulse(input logic [2:0] i);
        @(posedge mclk);
        fire <= 1'b1;
        fidx <= i;
        @(posedge mclk);
        fire <= 1'b0;
        settle(6);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = $urandom(70950);
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        settle(3);
        // Reset values and map
        check("SAMPLE_OUT", 32'(sample), 32'h0000_0000);
        check("XFER_HALFWORD", 32'(xhalf), 32'h0000_0001);
        check("XFER_BYTE", 32'(xbyte), 32'h0000_0000);
        check("IRQ", 32'(irq), 32'h0000_0000);
        foreach (ofs[i]) rd_reg(ofs[i], 32'h0000_0000, "reset read");
        $display("test reset done");

        // Software mode, source field set but unused
        wr_reg(OFS_CONFIG, 32'h0000_0004);
        repeat (4) begin
            w = $urandom();
            wr_reg(OFS_HOLDING, w);
            exp_out = w[9:0];
            settle(1);
            check("SAMPLE_OUT", 32'(sample), 32'(exp_out));
            rd_reg(OFS_HOLDING, 32'(exp_out), "holding");
        end
        wr_reg(OFS_HOLDING, 32'h0000_0155);
        wr_reg(OFS_HOLDING, 32'h0000_02aa);
        exp_out = 10'h2aa;
        pulse(3'h2);
        check("SAMPLE_OUT", 32'(sample), 32'(exp_out));
        wr_reg(OFS_OUT_LATCH, 32'h0000_0111);
        rd_reg(OFS_OUT_LATCH, 32'(exp_out), "latch");
        rd_reg(OFS_STATE, 32'h0000_0000, "flag off");
        $display("test software mode done");

        // Eight-bit mode
        wr_reg(OFS_CONFIG, 32'h0000_0010);
        settle(1);
        check("XFER_BYTE", 32'(xbyte), 32'h0000_0001);
        check("XFER_HALFWORD", 32'(xhalf), 32'h0000_0000);
        rd_reg(OFS_CONFIG, 32'h0000_0010, "config");
        w = $urandom() | 32'h0000_0300;
        wr_reg(OFS_HOLDING, w);
        exp_out = {w[7:0], 2'b00};
        settle(1);
        check("SAMPLE_OUT", 32'(sample), 32'(exp_out));
        rd_reg(OFS_HOLDING, 32'(exp_out), "holding 8");
        wr_reg(OFS_CONFIG, 32'h0000_0000);
        settle(1);
        check("XFER_HALFWORD", 32'(xhalf), 32'h0000_0001);
        $display("test width done");

        // Timer trigger, every source code
        for (int c = 0; c < 8; c++) begin
            wr_reg(OFS_CONFIG, 32'((c << 1) | 1));
            rd_reg(OFS_STATE, 32'h0000_0001, "flag enable");
            w = $urandom();
            wr_reg(OFS_HOLDING, w);
            rd_reg(OFS_STATE, 32'h0000_0000, "flag pending");
            pulse(3'((c + 1) % 6));
            check("SAMPLE_OUT", 32'(sample), 32'(exp_out));
            if (c < 6) begin
                pulse(3'(c));
                exp_out = w[9:0];
            end else begin
                for (int k = 0; k < 6; k++) pulse(3'(k));
            end
            check("SAMPLE_OUT", 32'(sample), 32'(exp_out));
            rd_reg(OFS_STATE, (c < 6) ? 32'h0000_0001 : 32'h0000_0000, "flag");
            wr_reg(OFS_CONFIG, 32'h0000_0000);
            rd_reg(OFS_STATE, 32'h0000_0000, "flag off");
        end
        $display("test trigger done");

        // Interrupt mask set and clear
        wr_reg(OFS_CONFIG, 32'h0000_0001);
        wr_reg(OFS_IRQ_SET, 32'h0000_0000);
        rd_reg(OFS_IRQ_MASK, 32'h0000_0000, "mask");
        check("IRQ", 32'(irq), 32'h0000_0000);
        wr_reg(OFS_IRQ_SET, 32'h0000_0001);
        rd_reg(OFS_IRQ_MASK, 32'h0000_0001, "mask");
        check("IRQ", 32'(irq), 32'h0000_0001);
        w = $urandom();
        wr_reg(OFS_HOLDING, w);
        settle(1);
        check("IRQ", 32'(irq), 32'h0000_0000);
        pulse(3'h0);
        exp_out = w[9:0];
        check("IRQ", 32'(irq), 32'h0000_0001);
        check("SAMPLE_OUT", 32'(sample), 32'(exp_out));
        wr_reg(OFS_IRQ_CLR, 32'h0000_0000);
        rd_reg(OFS_IRQ_MASK, 32'h0000_0001, "mask");
        wr_reg(OFS_IRQ_CLR, 32'h0000_0001);
        rd_reg(OFS_IRQ_MASK, 32'h0000_0000, "mask");
        check("IRQ", 32'(irq), 32'h0000_0000);
        // Overwrite event, its mask and its clear
        wr_reg(OFS_HOLDING, 32'h0000_0011);
        wr_reg(OFS_HOLDING, 32'h0000_0022);
        rd_reg(OFS_EVENTS, 32'h0000_0006, "events");
        wr_reg(OFS_IRQ_SET, 32'h0000_0004);
        settle(1);
        check("IRQ", 32'(irq), 32'h0000_0001);
        wr_reg(OFS_EVENTS, 32'h0000_0006);
        rd_reg(OFS_EVENTS, 32'h0000_0000, "events clear");
        check("IRQ", 32'(irq), 32'h0000_0000);
        $display("test interrupt done");

        // Soft reinitialisation
        wr_reg(OFS_CONFIG, 32'h0000_0013);
        wr_reg(OFS_IRQ_SET, 32'h0000_0001);
        wr_reg(OFS_CONTROL, 32'h0000_0000);
        rd_reg(OFS_CONFIG, 32'h0000_0013, "config kept");
        wr_reg(OFS_CONTROL, 32'h0000_0001);
        foreach (ofs[i]) rd_reg(ofs[i], 32'h0000_0000, "after reinit");
        settle(1);
        check("SAMPLE_OUT", 32'(sample), 32'h0000_0000);
        check("XFER_HALFWORD", 32'(xhalf), 32'h0000_0001);
        check("IRQ", 32'(irq), 32'h0000_0000);
        $display("test reinit done");
        settle(2);
        close_out();
    end
endmodule

`default_nettype wire
